// ### inc/fhp_pkg.sv
// fhp_pkg: offsets, reset values and types of the floppy host port
package fhp_pkg;
  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_MSR = 4'h4;
  localparam logic [3:0] IDX_DATA = 4'h5;
  localparam logic [3:0] IDX_DIR = 4'h7;
  localparam logic [7:0] DSR_RST = 8'h02;
  localparam logic CFG_NOFIFO_RST = 1'b1;
  localparam int MSR_RQM = 7;
  localparam int MSR_DIO = 6;
  localparam int MSR_NDM = 5;
  localparam int MSR_CB = 4;
  localparam int DIR_CHG = 7;
  localparam int DSR_SWRST = 7;
  localparam int DSR_PWD = 6;
  localparam int PRE_LO = 2;
  localparam int PRE_HI = 4;
  localparam int SPC_ND_BIT = 0;
  localparam int CFG_NOFIFO_BIT = 5;
  localparam int EXEC_BYTES = 512;
  localparam logic [4:0] CMD_SPECIFY = 5'h03;
  localparam logic [4:0] CMD_CONFIG = 5'h13;
  localparam logic [4:0] CMD_SENSE = 5'h08;
  localparam logic [4:0] CMD_READ = 5'h06;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_RECAL = 5'h07;
  localparam logic [4:0] CMD_SEEK = 5'h0F;
  localparam logic [7:0] ST0_INVALID = 8'h80;
  typedef enum logic [1:0] {PH_CMD, PH_EXEC, PH_RES} fhp_phase_e;
  typedef struct packed {
    logic [3:0] params;
    logic exec;
    logic rd;
    logic [2:0] results;
    logic bad;
  } fhp_cmd_s;
endpackage

// ### rtl/fhp_host_port.sv
// fhp_host_port: APB host port and phase sequencer of a floppy controller
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - rate control write sets rate from bits 1-0: 500K,300K,250K,1M
// - shared offset: reads give disk input status, writes go to rate control
// - status bit 7 is the inverse of the synced media changed pin
// - data port is an 8-bit read/write path for commands and results
// - data port writes fill a stack in command phase, else go to the drive; reads give the read buffer or a result byte
// - command, execution and result phases; a command may skip some
// - after reset the controller waits in command phase for a byte
// - ready flag drops after each byte and returns when next is wanted
// - after last command byte move on by itself and disable the FIFO
// - sector data moves only in the execution phase
// - execution bytes flagged by interrupt or DMA request per setup
// - setup options command decides FIFO enable state after software reset
// - execution ends after all bytes; no result means ready at once
// - active rate is the latest write of rate select or rate control
// - hardware reset loads rate select with 02h; software reset keeps it
// - with ready set, direction 0 means host write, 1 host read
// - busy reads 1 during a command and 0 after result phase end
module fhp_host_port #(
  parameter int ADDR_W = 8,
  parameter int STK_DEPTH = 16,
  parameter int XCNT_W = 16,
  parameter int EXEC_BYTES = fhp_pkg::EXEC_BYTES
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic MEDIA_CHANGED_N_IN,
  input wire logic [7:0] DRV_RDATA_IN,
  input wire logic DRV_RVALID_IN,
  output logic DRV_RREADY_OUT,
  output logic [7:0] DRV_WDATA_OUT,
  output logic DRV_WSTB_OUT,
  input wire logic [7:0] RES_BYTE_IN,
  output logic [2:0] RES_IDX_OUT,
  output logic [7:0] CMD_CODE_OUT,
  output logic EXEC_ACTIVE_OUT,
  output logic [1:0] RATE_CODE_OUT,
  output logic [2:0] PRECOMP_OUT,
  output logic POWER_DOWN_OUT,
  output logic FIFO_EN_OUT,
  output logic INTERRUPT_REQUEST_OUT,
  output logic DMA_REQUEST_N_OUT
);

  typedef struct packed {
    fhp_pkg::fhp_phase_e ph;
    logic [STK_DEPTH-1:0][7:0] stk;
    logic [3:0] cnt;
    fhp_pkg::fhp_cmd_s info;
    logic [2:0] res_idx;
    logic [XCNT_W-1:0] xcnt;
    logic [7:0] rbuf;
    logic rfull;
    logic host_transfer_ready;
    logic transfer_direction;
    logic cb;
    logic ndm;
    logic cfg_nofifo;
    logic fifo_en;
    logic [7:0] dsr;
    logic [1:0] rate;
    logic chg_s1;
    logic chg_s2;
    logic [31:0] prdata;
    logic [7:0] wdata;
    logic wstb;
  } fhp_state_s;

  fhp_state_s s_r;
  fhp_state_s s_nxt;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [3:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  // command table: parameter count, execution use, result count
  function automatic fhp_pkg::fhp_cmd_s cmd_info(input logic [4:0] c);
    cmd_info = '0;
    case (c)
      fhp_pkg::CMD_SPECIFY: cmd_info.params = 4'h2;
      fhp_pkg::CMD_CONFIG: cmd_info.params = 4'h3;
      fhp_pkg::CMD_SENSE: cmd_info.results = 3'h2;
      fhp_pkg::CMD_RECAL: cmd_info.params = 4'h1;
      fhp_pkg::CMD_SEEK: cmd_info.params = 4'h2;
      fhp_pkg::CMD_READ: begin
        cmd_info.params = 4'h8;
        cmd_info.exec = 1'b1;
        cmd_info.rd = 1'b1;
        cmd_info.results = 3'h7;
      end
      fhp_pkg::CMD_WRITE: begin
        cmd_info.params = 4'h8;
        cmd_info.exec = 1'b1;
        cmd_info.results = 3'h7;
      end
      default: begin
        cmd_info.results = 3'h1;
        cmd_info.bad = 1'b1;
      end
    endcase
  endfunction

  logic setup;
  logic wr;
  logic rd;
  logic mapped;
  logic dp_wr;
  logic dp_rd;
  logic dp_acc;
  logic in_exec;
  logic [7:0] wd;
  logic [7:0] main_status;

  assign setup = PSEL_IN & ~PENABLE_IN;
  assign wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign rd = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
  assign mapped = hit(PADDR_IN, fhp_pkg::IDX_MSR)
                | hit(PADDR_IN, fhp_pkg::IDX_DATA)
                | hit(PADDR_IN, fhp_pkg::IDX_DIR);
  assign wd = PWDATA_IN[7:0];
  assign in_exec = (s_r.ph == fhp_pkg::PH_EXEC);
  // byte moves only when ready and the direction agrees
  assign dp_wr = wr & hit(PADDR_IN, fhp_pkg::IDX_DATA)
               & s_r.host_transfer_ready & ~s_r.transfer_direction;
  assign dp_rd = rd & hit(PADDR_IN, fhp_pkg::IDX_DATA)
               & s_r.host_transfer_ready & s_r.transfer_direction;
  assign dp_acc = dp_wr | dp_rd;
  assign main_status = {s_r.host_transfer_ready, s_r.transfer_direction, s_r.ndm & in_exec, s_r.cb, 4'h0};

  logic fin;
  logic want;
  fhp_pkg::fhp_cmd_s ci;

  always_comb begin
    s_nxt = s_r;
    fin = 1'b0;
    want = 1'b1;
    ci = s_r.info;
    s_nxt.wstb = 1'b0;
    s_nxt.chg_s1 = MEDIA_CHANGED_N_IN;
    s_nxt.chg_s2 = s_r.chg_s1;
    // read data is captured in the setup cycle
    if (setup && !PWRITE_IN) begin
      s_nxt.prdata = '0;
      if (hit(PADDR_IN, fhp_pkg::IDX_MSR)) begin
        s_nxt.prdata[7:0] = main_status;
      end
      if (hit(PADDR_IN, fhp_pkg::IDX_DIR)) begin
        s_nxt.prdata[fhp_pkg::DIR_CHG] = ~s_r.chg_s2;
      end
      if (hit(PADDR_IN, fhp_pkg::IDX_DATA)) begin
        if (in_exec && s_r.info.rd) begin
          s_nxt.prdata[7:0] = s_r.rbuf;
        end else if (s_r.ph == fhp_pkg::PH_RES) begin
          s_nxt.prdata[7:0] = s_r.info.bad ? fhp_pkg::ST0_INVALID
                                           : RES_BYTE_IN;
        end
      end
    end
    case (s_r.ph)
      fhp_pkg::PH_CMD: begin
        if (dp_wr) begin
          s_nxt.cb = 1'b1;
          s_nxt.stk[s_r.cnt] = wd;
          if (s_r.cnt == 4'h0) begin
            ci = cmd_info(wd[4:0]);
          end
          s_nxt.info = ci;
          s_nxt.cnt = s_r.cnt + 4'h1;
          if (s_r.cnt == ci.params) begin
            s_nxt.cnt = 4'h0;
            s_nxt.fifo_en = 1'b0;
            if (s_nxt.stk[0][4:0] == fhp_pkg::CMD_SPECIFY) begin
              s_nxt.ndm = s_nxt.stk[2][fhp_pkg::SPC_ND_BIT];
            end
            if (s_nxt.stk[0][4:0] == fhp_pkg::CMD_CONFIG) begin
              s_nxt.cfg_nofifo =
                s_nxt.stk[2][fhp_pkg::CFG_NOFIFO_BIT];
            end
            if (ci.exec) begin
              s_nxt.ph = fhp_pkg::PH_EXEC;
              s_nxt.xcnt = XCNT_W'(EXEC_BYTES);
              s_nxt.transfer_direction = ci.rd;
            end else begin
              fin = 1'b1;
            end
          end
        end
      end
      fhp_pkg::PH_EXEC: begin
        if (s_r.info.rd) begin
          if (DRV_RVALID_IN && !s_r.rfull) begin
            s_nxt.rbuf = DRV_RDATA_IN;
            s_nxt.rfull = 1'b1;
          end
        end else if (dp_wr) begin
          s_nxt.wdata = wd;
          s_nxt.wstb = 1'b1;
        end
        if (dp_rd) begin
          s_nxt.rfull = 1'b0;
        end
        if (dp_acc) begin
          s_nxt.xcnt = s_r.xcnt - XCNT_W'(1);
          fin = (s_r.xcnt == XCNT_W'(1));
        end
      end
      fhp_pkg::PH_RES: begin
        if (dp_rd) begin
          s_nxt.res_idx = s_r.res_idx + 3'h1;
          if (s_r.res_idx == s_r.info.results - 3'h1) begin
            s_nxt.ph = fhp_pkg::PH_CMD;
            s_nxt.transfer_direction = 1'b0;
            s_nxt.cb = 1'b0;
          end
        end
      end
      default: s_nxt.ph = fhp_pkg::PH_CMD;
    endcase
    // end of command or execution stage: result phase or idle
    if (fin) begin
      s_nxt.res_idx = 3'h0;
      if (ci.results != 3'h0) begin
        s_nxt.ph = fhp_pkg::PH_RES;
        s_nxt.transfer_direction = 1'b1;
      end else begin
        s_nxt.ph = fhp_pkg::PH_CMD;
        s_nxt.transfer_direction = 1'b0;
        s_nxt.cb = 1'b0;
      end
    end
    if (s_nxt.ph == fhp_pkg::PH_EXEC && s_nxt.info.rd) begin
      want = s_nxt.rfull;
    end
    s_nxt.host_transfer_ready = want & ~dp_acc;
    if (wr && hit(PADDR_IN, fhp_pkg::IDX_DIR)) begin
      s_nxt.rate = wd[1:0];
    end
    if (wr && hit(PADDR_IN, fhp_pkg::IDX_MSR)) begin
      s_nxt.dsr = {1'b0, wd[6:0]};
      s_nxt.rate = wd[1:0];
      // self-clearing software reset keeps rates and setup
      if (wd[fhp_pkg::DSR_SWRST]) begin
        s_nxt.ph = fhp_pkg::PH_CMD;
        s_nxt.cnt = 4'h0;
        s_nxt.res_idx = 3'h0;
        s_nxt.rfull = 1'b0;
        s_nxt.transfer_direction = 1'b0;
        s_nxt.cb = 1'b0;
        s_nxt.host_transfer_ready = 1'b1;
        s_nxt.fifo_en = ~s_r.cfg_nofifo;
      end
    end
    if (!RST_N_IN) begin
      s_nxt = '0;
      s_nxt.dsr = fhp_pkg::DSR_RST;
      s_nxt.rate = fhp_pkg::DSR_RST[1:0];
      s_nxt.host_transfer_ready = 1'b1;
      s_nxt.cfg_nofifo = fhp_pkg::CFG_NOFIFO_RST;
      s_nxt.fifo_en = ~fhp_pkg::CFG_NOFIFO_RST;
      s_nxt.chg_s1 = 1'b1;
      s_nxt.chg_s2 = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    s_r <= s_nxt;
  end

  assign PRDATA_OUT = s_r.prdata;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;
  assign DRV_RREADY_OUT = in_exec & s_r.info.rd & ~s_r.rfull;
  assign DRV_WDATA_OUT = s_r.wdata;
  assign DRV_WSTB_OUT = s_r.wstb;
  assign RES_IDX_OUT = s_r.res_idx;
  assign CMD_CODE_OUT = s_r.stk[0];
  assign EXEC_ACTIVE_OUT = in_exec;
  assign RATE_CODE_OUT = s_r.rate;
  assign PRECOMP_OUT = s_r.dsr[fhp_pkg::PRE_HI:fhp_pkg::PRE_LO];
  assign POWER_DOWN_OUT = s_r.dsr[fhp_pkg::DSR_PWD];
  assign FIFO_EN_OUT = s_r.fifo_en;
  assign INTERRUPT_REQUEST_OUT = in_exec & s_r.ndm & s_r.host_transfer_ready;
  assign DMA_REQUEST_N_OUT = ~(in_exec & ~s_r.ndm & s_r.host_transfer_ready);

  default clocking cb_clk @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  a_rate_ctrl: assert property (
    wr && hit(PADDR_IN, fhp_pkg::IDX_DIR)
    |=> RATE_CODE_OUT == $past(PWDATA_IN[1:0]))
    else $error("rate control write not applied");

  a_dir_read: assert property (
    setup && !PWRITE_IN && hit(PADDR_IN, fhp_pkg::IDX_DIR)
    ##1 PSEL_IN && PENABLE_IN
    |-> PRDATA_OUT == {24'h0, ~$past(s_r.chg_s2), 7'h0})
    else $error("disk input status read wrong");

  a_dcr_keeps: assert property (
    wr && hit(PADDR_IN, fhp_pkg::IDX_DIR)
    |=> $stable(s_r.dsr) && $stable(s_r.fifo_en))
    else $error("rate control write touched other state");

  a_reset_vals: assert property (
    $rose(RST_N_IN) |-> s_r.dsr == fhp_pkg::DSR_RST
    && s_r.ph == fhp_pkg::PH_CMD && s_r.host_transfer_ready && !s_r.transfer_direction)
    else $error("reset state wrong");

  a_rqm_drop: assert property (
    dp_acc |=> !s_r.host_transfer_ready ##1 (s_r.host_transfer_ready || s_r.ph == fhp_pkg::PH_EXEC))
    else $error("ready flag not cycled");

  a_cmd_dir: assert property (
    s_r.ph == fhp_pkg::PH_CMD |-> !s_r.transfer_direction)
    else $error("direction set in command phase");

  a_res_dir: assert property (
    s_r.ph == fhp_pkg::PH_RES |-> s_r.transfer_direction && s_r.cb)
    else $error("result phase flags wrong");

  a_fifo_off: assert property (
    s_r.ph == fhp_pkg::PH_CMD && s_r.cb
    ##1 s_r.ph != fhp_pkg::PH_CMD |-> !s_r.fifo_en)
    else $error("fifo still enabled after command");

  a_req_mode: assert property (
    !DMA_REQUEST_N_OUT || INTERRUPT_REQUEST_OUT
    |-> in_exec && (INTERRUPT_REQUEST_OUT == s_r.ndm))
    else $error("transfer request in wrong mode");

  a_exec_only: assert property (
    DRV_WSTB_OUT |-> $past(in_exec) && $past(dp_wr))
    else $error("sector byte outside execution");

  a_busy_end: assert property (
    s_r.ph == fhp_pkg::PH_RES && dp_rd
    && s_r.res_idx == s_r.info.results - 3'h1
    |=> !s_r.cb && s_r.ph == fhp_pkg::PH_CMD)
    else $error("busy not cleared after results");

endmodule // fhp_host_port
`default_nettype wire

// ### testbench/fhp_drive_model.sv
// fhp_drive_model: drive-side byte source, write sink and result bytes
`timescale 1ns/1ps
`default_nettype none
module fhp_drive_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] gap_in,
  input wire logic rready_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  input wire logic [7:0] wdata_in,
  input wire logic wstb_in,
  input wire logic [2:0] res_idx_in,
  output logic [7:0] res_byte_out,
  output logic [7:0] wr_cnt_out,
  output logic [7:0] wr_last_out
);
  logic [7:0] nxt_byte;
  logic [3:0] wait_cnt;
  assign rvalid_out = (wait_cnt == 4'h0);
  // idle data line shows the inverse so a stale byte is never taken
  assign rdata_out = rvalid_out ? nxt_byte : ~nxt_byte;
  assign res_byte_out = 8'hA0 | {5'h00, res_idx_in};
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      nxt_byte <= 8'hC0;
      wait_cnt <= 4'h0;
      wr_cnt_out <= 8'h00;
      wr_last_out <= 8'h00;
    end else begin
      if (rvalid_out && rready_in) begin
        nxt_byte <= nxt_byte + 8'h01;
        wait_cnt <= gap_in;
      end else if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
      if (wstb_in) begin
        wr_cnt_out <= wr_cnt_out + 8'h01;
        wr_last_out <= wdata_in;
      end
    end
  end
endmodule // fhp_drive_model
`default_nettype wire

// ### testbench/floppy_ctrl_host_port_phases_tb.sv
// floppy_ctrl_host_port_phases_tb: self-checking bench of the host port
`timescale 1ns/1ps
`default_nettype none
module floppy_ctrl_host_port_phases_tb;
  localparam logic [7:0] A_MSR = {2'b00, fhp_pkg::IDX_MSR, 2'b00};
  localparam logic [7:0] A_DAT = {2'b00, fhp_pkg::IDX_DATA, 2'b00};
  localparam logic [7:0] A_DIR = {2'b00, fhp_pkg::IDX_DIR, 2'b00};
  typedef struct packed {
    logic [7:0] wd;
    logic med;
    logic [1:0] rate;
    logic [7:0] rd;
  } fhp_row_s;
  logic clk, rst_n, psel, pen, pwr, pready, pslverr, media_n;
  logic [7:0] paddr, rdat, wdat, rbyte, cmd_code, wr_cnt, wr_last;
  logic [31:0] pwdata, prdata, r;
  logic rvalid, rready, wstb, exec, pdn, fifo_en, irq, dma_n, held, e;
  logic [2:0] ridx, precomp;
  logic [1:0] rate;
  logic [3:0] gap;
  int fails, checks_done;
  fhp_row_s rows [4] = '{'{8'hFC, 1'b1, 2'b00, 8'h00},
    '{8'h01, 1'b0, 2'b01, 8'h80}, '{8'hAE, 1'b1, 2'b10, 8'h00},
    '{8'h57, 1'b0, 2'b11, 8'h80}};
  fhp_host_port #(.EXEC_BYTES(4)) u_fhp_host_port (.REF_CLK_IN(clk),
    .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .MEDIA_CHANGED_N_IN(media_n), .DRV_RDATA_IN(rdat),
    .DRV_RVALID_IN(rvalid), .DRV_RREADY_OUT(rready), .DRV_WDATA_OUT(wdat),
    .DRV_WSTB_OUT(wstb), .RES_BYTE_IN(rbyte), .RES_IDX_OUT(ridx),
    .CMD_CODE_OUT(cmd_code), .EXEC_ACTIVE_OUT(exec), .RATE_CODE_OUT(rate),
    .PRECOMP_OUT(precomp), .POWER_DOWN_OUT(pdn), .FIFO_EN_OUT(fifo_en),
    .INTERRUPT_REQUEST_OUT(irq), .DMA_REQUEST_N_OUT(dma_n));
  fhp_drive_model u_fhp_drive_model (.clk_in(clk), .rst_n_in(rst_n),
    .gap_in(gap), .rready_in(rready), .rdata_out(rdat), .rvalid_out(rvalid),
    .wdata_in(wdat), .wstb_in(wstb), .res_idx_in(ridx),
    .res_byte_out(rbyte), .wr_cnt_out(wr_cnt), .wr_last_out(wr_last));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
      input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      fails++;
      $display("mismatch %s exp %h got %h", nm, x, g);
    end
  endtask
  // setup cycle, then access held until pready; keep leaves psel up
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic keep, output logic [31:0] rd, output logic err);
    int n;
    if (!held) @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fails++;
    rd = prdata;
    err = pslverr;
    held = keep;
    if (!keep) begin
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 1'b0, r, e);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
      input logic [31:0] x);
    apb(1'b0, a, 8'h00, 1'b0, r, e);
    chk(nm, x, r);
  endtask
  task automatic wait_rdy(input logic dir);
    int n;
    n = 0;
    do begin
      apb(1'b0, A_MSR, 8'h00, 1'b0, r, e);
      n++;
    end while (r[7] !== 1'b1 && n < 40);
    chk("rdy", 32'h1, {31'h0, r[7]});
    chk("dir", {31'h0, dir}, {31'h0, r[6]});
  endtask
  task automatic cmd(input logic [4:0] code, input int np,
      input logic [7:0] p2);
    for (int i = 0; i <= np; i++) begin
      wait_rdy(1'b0);
      wr(A_DAT, i == 0 ? {3'h0, code} : (i == 2 ? p2 : 8'h00));
    end
  endtask
  task automatic res(input int n, input logic bad);
    for (int i = 0; i < n; i++) begin
      wait_rdy(1'b1);
      rchk("result", A_DAT, bad ? 32'h80 : 32'hA0 + i);
    end
  endtask
  initial begin
    #(25 * 40000);
    fails++;
    final_report;
  end
  initial begin
    {psel, pen, pwr, held, rst_n, media_n} = 6'b000001;
    {paddr, pwdata, gap, fails, checks_done} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rchk("msr", A_MSR, 32'h80);
    chk("rate", 32'h2, {30'h0, rate});
    foreach (rows[i]) begin
      media_n <= rows[i].med;
      repeat (4) @(posedge clk);
      wr(A_DIR, rows[i].wd);
      #1 chk("rate", {30'h0, rows[i].rate}, {30'h0, rate});
      rchk("dir_reg", A_DIR, {24'h0, rows[i].rd});
    end
    apb(1'b0, 8'h00, 8'h00, 1'b0, r, e);
    chk("slverr", 32'h1, {31'h0, e});
    wr(A_MSR, 8'h0C);
    #1 chk("prate", 32'h0C, {27'h0, precomp, rate});
    wr(A_DIR, 8'h03);
    #1 chk("rate", 32'h3, {30'h0, rate});
    wait_rdy(1'b0);
    apb(1'b1, A_DAT, {3'h0, fhp_pkg::CMD_SENSE}, 1'b1, r, e);
    apb(1'b0, A_MSR, 8'h00, 1'b0, r, e);
    chk("rdy_drop", 32'h0, {31'h0, r[7]});
    chk("busy", 32'h1, {31'h0, r[4]});
    res(2, 1'b0);
    rchk("msr", A_MSR, 32'h80);
    cmd(5'h1F, 0, 8'h00);
    res(1, 1'b1);
    cmd(fhp_pkg::CMD_CONFIG, 3, 8'h00);
    cmd(fhp_pkg::CMD_SENSE, 0, 8'h00);
    wr(A_MSR, 8'h8E);
    #1 chk("prate", 32'h0E, {27'h0, precomp, rate});
    chk("fifo", 32'h1, {31'h0, fifo_en});
    rchk("msr", A_MSR, 32'h80);
    cmd(fhp_pkg::CMD_SPECIFY, 2, 8'h01);
    #1 chk("fifo", 32'h0, {31'h0, fifo_en});
    chk("code", 32'h03, {24'h0, cmd_code});
    cmd(fhp_pkg::CMD_WRITE, 8, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wait_rdy(1'b0);
      #1 chk("req", 32'h3, {30'h0, irq, dma_n});
      wr(A_DAT, 8'h30 + i);
    end
    repeat (2) @(posedge clk);
    #1 chk("wr", 32'h0433, {16'h0, wr_cnt, wr_last});
    res(7, 1'b0);
    cmd(fhp_pkg::CMD_SPECIFY, 2, 8'h00);
    gap <= 4'h3;
    cmd(fhp_pkg::CMD_READ, 8, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wait_rdy(1'b1);
      #1 chk("req", 32'h0, {30'h0, irq, dma_n});
      rchk("exec_rd", A_DAT, 32'hC0 + i);
    end
    res(7, 1'b0);
    rchk("msr", A_MSR, 32'h80);
    chk("exec", 32'h0, {31'h0, exec});
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("prate", 32'h02, {26'h0, pdn, precomp, rate});
    rchk("msr", A_MSR, 32'h80);
    final_report;
  end
endmodule // floppy_ctrl_host_port_phases_tb
`default_nettype wire
